// [hdl/ffi_pkg.sv]
// Purpose: Shared constants and types of the fault flag block.
// Assumes: 100 MHz core clock.
// Notes:   Register indices are the byte after the target address.
package ffi_pkg;

  // Target address and register indices
  localparam logic [6:0] I2C_ADDR   = 7'h53;
  localparam logic [7:0] IDX_ENABLE = 8'h10;
  localparam logic [7:0] IDX_IND    = 8'h12;
  localparam logic [7:0] IDX_GPIO   = 8'h20;
  localparam logic [7:0] IDX_VIN    = 8'h80;
  localparam logic [7:0] IDX_TORCH  = 8'hA0;
  localparam logic [7:0] IDX_FLASH  = 8'hB0;
  localparam logic [7:0] IDX_DUR    = 8'hC0;
  localparam logic [7:0] IDX_FLAGS  = 8'hD0;
  localparam logic [7:0] IDX_CFG1   = 8'hE0;
  localparam logic [7:0] IDX_CFG2   = 8'hF0;

  // Reset values
  localparam logic [7:0] RST_ENABLE = 8'hF8;
  localparam logic [7:0] RST_IND    = 8'hF8;
  localparam logic [7:0] RST_GPIO   = 8'h80;
  localparam logic [7:0] RST_VIN    = 8'hF8;
  localparam logic [7:0] RST_TORCH  = 8'hFA;
  localparam logic [7:0] RST_FLASH  = 8'hFD;
  localparam logic [7:0] RST_DUR    = 8'hEF;
  localparam logic [7:0] RST_FLAGS  = 8'h00;
  localparam logic [7:0] RST_CFG1   = 8'h6A;
  localparam logic [7:0] RST_CFG2   = 8'hF0;

  // Field positions
  localparam int EN_EDGE_BIT     = 2;
  localparam int GPIO_PA1_CTL    = 0;
  localparam int GPIO_PA2_CTL    = 3;
  localparam int VIN_EN_BIT      = 0;
  localparam int CFG1_THERM_MODE = 4;
  localparam int CFG1_PA1_POL    = 5;
  localparam int CFG1_PA2_POL    = 6;
  localparam int CFG2_THERM_OFF  = 1;
  localparam int CFG2_VIN_OFF    = 3;
  localparam int DUR_W           = 5;

  // Flag bit positions
  localparam int FL_TIMEOUT = 0;
  localparam int FL_THERMAL = 1;
  localparam int FL_LED     = 2;
  localparam int FL_PA1     = 3;
  localparam int FL_PA2     = 4;
  localparam int FL_LEDTEMP = 5;
  localparam int FL_VIN     = 7;

  // Timing
  localparam int CLK_MHZ      = 100;
  localparam int OVP_DLY_NS   = 2000;
  localparam int OVP_CYC      = (OVP_DLY_NS * CLK_MHZ + 999) / 1000;
  localparam int SHORT_DLY_US = 250;
  localparam int SHORT_CYC    = SHORT_DLY_US * CLK_MHZ;
  localparam int TO_STEP_US   = 32;
  localparam int TO_STEP_CYC  = TO_STEP_US * CLK_MHZ;

  typedef enum logic [1:0] {
    LED_OFF   = 2'b00,
    LED_IND   = 2'b01,
    LED_TORCH = 2'b10,
    LED_FLASH = 2'b11
  } ffi_mode_type;

  typedef enum logic [2:0] {
    I2C_IDLE  = 3'b000,
    I2C_ADDRESS = 3'b001,
    I2C_INDEX = 3'b010,
    I2C_WDATA = 3'b011,
    I2C_RDATA = 3'b100
  } ffi_i2c_state_type;

endpackage : ffi_pkg

// [hdl/ffi_i2c_target.sv]
// Purpose: Two-wire target port giving byte access to the register bank.
// Assumes: Core clock far faster than the bus clock.
// Notes:   Bus pins are sampled; a read reuses the last written index.
`timescale 1ns/100ps
module ffi_i2c_target
  import ffi_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // Bus pins
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_oe,
  // Register side
  output logic            o_wr_pulse,
  output logic            o_rd_pulse,
  output logic [7:0]      o_idx,
  output logic [7:0]      o_wr_data,
  output logic [7:0]      o_rd_byte,
  input  wire logic [7:0] i_rd_data
);

  typedef struct packed {
    logic [1:0]        s1, s2, s3, f, fp;
    ffi_i2c_state_type st;
    logic              ack;
    logic [3:0]        bitc;
    logic [7:0]        sr, idx, wdat;
    logic              wr, rd, oe;
  } ffi_i2c_type;

  ffi_i2c_type r, n;
  logic scl, sda, start, stop, rise, fall;

  always_comb begin
    n    = r;
    n.wr = 1'b0;
    n.rd = 1'b0;
    n.s1 = {i_scl, i_sda};
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.f  = (r.s2 & ~(r.s2 ^ r.s3)) | (r.f & (r.s2 ^ r.s3));
    n.fp = r.f;
    scl   = r.f[1];
    sda   = r.f[0];
    start = scl && r.fp[1] && r.fp[0] && !sda;
    stop  = scl && r.fp[1] && !r.fp[0] && sda;
    rise  = scl && !r.fp[1];
    fall  = !scl && r.fp[1];
    if (start) begin
      n.st   = I2C_ADDRESS;
      n.bitc = 4'h0;
      n.ack  = 1'b0;
      n.oe   = 1'b0;
    end else if (stop) begin
      n.st  = I2C_IDLE;
      n.ack = 1'b0;
      n.oe  = 1'b0;
    end else if (r.st != I2C_IDLE && rise) begin
      if (!r.ack && r.st != I2C_RDATA) begin
        n.sr   = {r.sr[6:0], sda};
        n.bitc = r.bitc + 4'h1;
      end else if (!r.ack) begin
        n.bitc = r.bitc + 4'h1;
      end else if (r.st == I2C_RDATA && sda) begin
        n.st  = I2C_IDLE;
        n.ack = 1'b0;
      end
    end else if (r.st != I2C_IDLE && fall) begin
      if (r.ack) begin
        n.ack  = 1'b0;
        n.bitc = 4'h0;
        n.oe   = 1'b0;
        if (r.st == I2C_RDATA) begin
          n.sr = i_rd_data;
          n.oe = ~i_rd_data[7];
          n.rd = 1'b1;
        end
      end else if (r.bitc == 4'h8) begin
        n.ack = 1'b1;
        unique case (r.st)
          I2C_ADDRESS: begin
            if (r.sr[7:1] == I2C_ADDR) begin
              n.oe = 1'b1;
              n.st = r.sr[0] ? I2C_RDATA : I2C_INDEX;
            end else begin
              n.st  = I2C_IDLE;
              n.ack = 1'b0;
            end
          end
          I2C_INDEX: begin
            n.idx = r.sr;
            n.oe  = 1'b1;
            n.st  = I2C_WDATA;
          end
          I2C_WDATA: begin
            n.wdat = r.sr;
            n.wr   = 1'b1;
            n.oe   = 1'b1;
          end
          I2C_RDATA: n.oe = 1'b0;
          default:   n.st = I2C_IDLE;
        endcase
      end else if (r.st == I2C_RDATA) begin
        n.sr = {r.sr[6:0], 1'b0};
        n.oe = ~r.sr[6];
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      r <= '{s1: 2'h3, s2: 2'h3, s3: 2'h3, f: 2'h3, fp: 2'h3,
             st: I2C_IDLE, ack: 1'b0, bitc: 4'h0, sr: 8'h00,
             idx: 8'h00, wdat: 8'h00, wr: 1'b0, rd: 1'b0, oe: 1'b0};
    end else begin
      r <= n;
    end
  end

  assign o_sda_oe   = r.oe;
  assign o_wr_pulse = r.wr;
  assign o_rd_pulse = r.rd;
  assign o_idx      = r.idx;
  assign o_wr_data  = r.wdat;
  assign o_rd_byte  = r.sr;

endmodule : ffi_i2c_target

// [hdl/ffi_fault_flags.sv]
// Purpose: Fault and event flag bank with flash control and bus access.
// Assumes: Comparator and pin inputs are asynchronous to i_clk.
// Notes:   Flags are sticky and clear on a bus read of the flag register.
// Notes on behaviour
// - Reading flags clears the bits just returned
// - Timeout flag set when pulse outlives timeout
// - Trigger low or mode off ends pulse quietly
// - Enable pin low or new pulse clears timeout
// - Overheat stops converter, sources, sets thermal flag
// - Restart needs cool, flags read, software enable
// - Open or shorted LED sets fault flag
// - Short must last 250us before flagging
// - Open LED flagged 2us after comparator trip
// - LED fault clears only on pin, read
// - Thermistor trip while lit sets LED temperature flag
// - Thermistor cutback lifts after recovery and read
// - Supply monitor trip sets supply flag
// - Supply cutback lifts after recovery and read
// - First pin event in its role sets bit 3
// - Second pin event in its role sets bit 4
// - Polarity bit picks rising or falling event
// - Start and stop detected while clock high
// - Answers address 0x53, write 0xA6, read 0xA7
// - Write gives index byte then data byte
// - Bytes MSB first; target acknowledges each byte it receives
// - Mode field cleared whenever a pulse ends
`timescale 1ns/100ps
module ffi_fault_flags
  import ffi_pkg::*;
#(
  parameter int unsigned P_TO_STEP_CYC = TO_STEP_CYC,
  parameter int unsigned P_SHORT_CYC   = SHORT_CYC
)
(
  // Clock and reset
  input  wire logic  i_clk,
  input  wire logic  i_rst,
  // Two-wire bus
  input  wire logic  i_scl,
  input  wire logic  i_sda,
  output logic       o_sda,
  output logic       o_sda_oe,
  // Control pins
  input  wire logic  i_hardware_enable_pin,
  input  wire logic  i_strobe,
  input  wire logic  i_first_interrupt_pin,
  input  wire logic  i_second_interrupt_pin,
  // Comparators
  input  wire logic  i_over_temp,
  input  wire logic  i_output_overvoltage_comparator,
  input  wire logic  i_led_short,
  input  wire logic  i_thermistor_low,
  input  wire logic  i_supply_low,
  // Power stage
  output logic       o_boost_en,
  output logic [1:0] o_led_mode
);

  typedef struct packed {
    logic [8:0]   s1, s2, s3, f, fp;
    logic [7:0]   en, ind, gpio, vin, torch, fla, dur, flags, cfg1, cfg2;
    logic         flash, by_strobe;
    logic [23:0]  tcnt, ovp_cnt, sh_cnt;
    logic         therm_lock, ltemp_lock, vin_lock;
    ffi_mode_type led;
    logic         boost, sda;
  } ffi_state_type;

  ffi_state_type r, n;

  logic       wr_pulse, rd_pulse, rd_fl, wr_en;
  logic [7:0] idx, wr_data, rd_byte, rd_data, set_v, fl;
  logic       en_pin, strobe, pa1, pa2, otemp, output_overvoltage_comparator, lshort, tlow, vlow;
  logic       strobe_rise, ev1, ev2, lit, start, tmo, early, kill;
  logic       off_req, torch_req;
  logic [1:0] mode;

  function automatic logic pin_event(input logic now, input logic prev,
                                     input logic pol);
    pin_event = pol ? (now && !prev) : (!now && prev);
  endfunction : pin_event

  ffi_i2c_target u_target (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_scl      (i_scl),
    .i_sda      (i_sda),
    .o_sda_oe   (o_sda_oe),
    .o_wr_pulse (wr_pulse),
    .o_rd_pulse (rd_pulse),
    .o_idx      (idx),
    .o_wr_data  (wr_data),
    .o_rd_byte  (rd_byte),
    .i_rd_data  (rd_data)
  );

  // Register readback
  always_comb begin
    unique case (idx)
      IDX_ENABLE: rd_data = r.en;
      IDX_IND:    rd_data = r.ind;
      IDX_GPIO:   rd_data = r.gpio;
      IDX_VIN:    rd_data = r.vin;
      IDX_TORCH:  rd_data = r.torch;
      IDX_FLASH:  rd_data = r.fla;
      IDX_DUR:    rd_data = r.dur;
      IDX_FLAGS:  rd_data = r.flags;
      IDX_CFG1:   rd_data = r.cfg1;
      IDX_CFG2:   rd_data = r.cfg2;
      default:    rd_data = 8'h00;
    endcase
  end

  always_comb begin
    n    = r;
    n.s1 = {i_hardware_enable_pin, i_strobe, i_first_interrupt_pin,
            i_second_interrupt_pin, i_over_temp,
            i_output_overvoltage_comparator, i_led_short,
            i_thermistor_low, i_supply_low};
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.f  = (r.s2 & ~(r.s2 ^ r.s3)) | (r.f & (r.s2 ^ r.s3));
    n.fp = r.f;
    {en_pin, strobe, pa1, pa2, otemp, output_overvoltage_comparator, lshort, tlow, vlow} = r.f;
    strobe_rise = strobe && !r.fp[7];
    ev1 = pin_event(pa1, r.fp[6], r.cfg1[CFG1_PA1_POL]);
    ev2 = pin_event(pa2, r.fp[5], r.cfg1[CFG1_PA2_POL]);
    rd_fl = rd_pulse && idx == IDX_FLAGS;
    wr_en = wr_pulse && idx == IDX_ENABLE;

    // Software writes
    if (wr_pulse) begin
      unique case (idx)
        IDX_ENABLE: n.en    = wr_data;
        IDX_IND:    n.ind   = wr_data;
        IDX_GPIO:   n.gpio  = wr_data;
        IDX_VIN:    n.vin   = wr_data;
        IDX_TORCH:  n.torch = wr_data;
        IDX_FLASH:  n.fla   = wr_data;
        IDX_DUR:    n.dur   = wr_data;
        IDX_CFG1:   n.cfg1  = wr_data;
        IDX_CFG2:   n.cfg2  = wr_data;
        default:    n.en    = r.en;
      endcase
    end
    mode = n.en[1:0];
    lit  = r.led == LED_TORCH || r.led == LED_FLASH;

    // Fault qualification counters
    n.ovp_cnt = (lit && output_overvoltage_comparator) ? r.ovp_cnt + 24'h1 : 24'h0;
    if (r.ovp_cnt == 24'(OVP_CYC)) begin
      n.ovp_cnt = r.ovp_cnt;
    end
    n.sh_cnt = (lit && lshort) ? r.sh_cnt + 24'h1 : 24'h0;
    if (r.sh_cnt == 24'(P_SHORT_CYC)) begin
      n.sh_cnt = r.sh_cnt;
    end

    // Flash pulse
    tmo = r.flash &&
          r.tcnt >= 24'((r.dur[DUR_W-1:0] + 1) * P_TO_STEP_CYC) - 24'h1;
    early = r.flash && ((r.by_strobe && !r.en[EN_EDGE_BIT] && !strobe) ||
            (wr_en && wr_data[1:0] == LED_OFF));
    n.therm_lock = otemp || (r.therm_lock &&
                   !(r.flags[FL_THERMAL] == 1'b0 && wr_en &&
                   wr_data[1:0] != LED_OFF));
    // Releasing write must not be cancelled by the old lock
    kill  = !en_pin || n.therm_lock;
    start = !r.flash && !kill &&
            (strobe_rise || (wr_en && wr_data[1:0] == LED_FLASH));

    // Event sets
    set_v              = 8'h00;
    set_v[FL_TIMEOUT]  = tmo;
    set_v[FL_THERMAL]  = otemp;
    set_v[FL_LED]      = lit && ((output_overvoltage_comparator && r.ovp_cnt == 24'(OVP_CYC) - 24'h1)
                         || (lshort && r.sh_cnt == 24'(P_SHORT_CYC)
                         - 24'h1));
    set_v[FL_PA1]      = !r.gpio[GPIO_PA1_CTL] && ev1;
    set_v[FL_PA2]      = !r.gpio[GPIO_PA2_CTL] && ev2;
    set_v[FL_LEDTEMP]  = lit && r.cfg1[CFG1_THERM_MODE] && tlow;
    set_v[FL_VIN]      = r.vin[VIN_EN_BIT] && vlow;

    // Cutback locks
    n.ltemp_lock = set_v[FL_LEDTEMP] ||
                   (r.ltemp_lock && (tlow || r.flags[FL_LEDTEMP]));
    n.vin_lock   = set_v[FL_VIN] ||
                   (r.vin_lock && (vlow || r.flags[FL_VIN]));

    if (start) begin
      n.flash     = 1'b1;
      n.by_strobe = strobe_rise;
      n.tcnt      = 24'h0;
      n.en[1:0]   = LED_FLASH;
    end else if (r.flash) begin
      n.tcnt = r.tcnt + 24'h1;
      if (tmo || early || kill) begin
        n.flash   = 1'b0;
        n.en[1:0] = LED_OFF;
      end
    end
    if (kill && !start && !r.flash && mode != LED_OFF) begin
      n.en[1:0] = LED_OFF;
    end

    // Sticky flags, event wins over read clear
    fl = rd_fl ? (r.flags & ~rd_byte) : r.flags;
    if (start) begin
      fl[FL_TIMEOUT] = 1'b0;
    end
    n.flags = fl | set_v;
    if (!en_pin) begin
      n.flags[FL_TIMEOUT] = 1'b0;
      n.flags[FL_LED]     = 1'b0;
    end

    // Power stage drive
    off_req   = (n.ltemp_lock && r.cfg2[CFG2_THERM_OFF]) ||
                (n.vin_lock && r.cfg2[CFG2_VIN_OFF]);
    torch_req = n.ltemp_lock || n.vin_lock;
    if (n.therm_lock || !en_pin) begin
      n.led = LED_OFF;
    end else if (n.flash) begin
      n.led = off_req ? LED_OFF : (torch_req ? LED_TORCH : LED_FLASH);
    end else if (n.en[1:0] == LED_TORCH) begin
      n.led = off_req ? LED_OFF : LED_TORCH;
    end else if (n.en[1:0] == LED_IND && !r.cfg1[CFG1_THERM_MODE]) begin
      n.led = LED_IND;
    end else begin
      n.led = LED_OFF;
    end
    n.boost = n.led == LED_TORCH || n.led == LED_FLASH;
    n.sda   = 1'b0;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      r <= '{s1: 9'h000, s2: 9'h000, s3: 9'h000, f: 9'h000, fp: 9'h000,
             en: RST_ENABLE, ind: RST_IND, gpio: RST_GPIO, vin: RST_VIN,
             torch: RST_TORCH, fla: RST_FLASH, dur: RST_DUR,
             flags: RST_FLAGS, cfg1: RST_CFG1, cfg2: RST_CFG2,
             flash: 1'b0, by_strobe: 1'b0, tcnt: 24'h0, ovp_cnt: 24'h0,
             sh_cnt: 24'h0, therm_lock: 1'b0, ltemp_lock: 1'b0,
             vin_lock: 1'b0, led: LED_OFF, boost: 1'b0, sda: 1'b0};
    end else begin
      r <= n;
    end
  end

  assign o_sda      = r.sda;
  assign o_boost_en = r.boost;
  assign o_led_mode = r.led;

  // Checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  property p_read_clear;
    rd_fl && set_v == 8'h00 && en_pin |=> (r.flags & $past(rd_byte)) == 8'h00;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("flag read did not clear reported bits");

  property p_timeout_set;
    tmo && en_pin |=> r.flags[FL_TIMEOUT] && !r.flash;
  endproperty
  a_timeout_set: assert property (p_timeout_set)
    else $error("timeout did not set flag");

  property p_early_end;
    early && !tmo && !r.flags[FL_TIMEOUT] |=> !r.flash ##0
      !r.flags[FL_TIMEOUT];
  endproperty
  a_early_end: assert property (p_early_end)
    else $error("early end set timeout or kept pulse");

  property p_pin_clear;
    !en_pin |=> !r.flags[FL_TIMEOUT] && !r.flags[FL_LED] && !r.flash;
  endproperty
  a_pin_clear: assert property (p_pin_clear)
    else $error("enable pin low kept flags");

  property p_overheat;
    otemp |=> r.led == LED_OFF && !r.boost && r.flags[FL_THERMAL];
  endproperty
  a_overheat: assert property (p_overheat)
    else $error("overheat did not stop output");

  property p_therm_hold;
    r.therm_lock && (otemp || r.flags[FL_THERMAL]) |=> r.therm_lock;
  endproperty
  a_therm_hold: assert property (p_therm_hold)
    else $error("thermal lock released too early");

  property p_ovp_delay;
    lit && output_overvoltage_comparator && r.ovp_cnt < 24'(OVP_CYC) - 24'h1 && !lshort && en_pin
      && !r.flags[FL_LED] |=> !r.flags[FL_LED];
  endproperty
  a_ovp_delay: assert property (p_ovp_delay)
    else $error("open fault flagged before delay");

  property p_short_delay;
    lit && lshort && !output_overvoltage_comparator && r.sh_cnt < 24'(P_SHORT_CYC) - 24'h1
      && !r.flags[FL_LED] |=> !r.flags[FL_LED];
  endproperty
  a_short_delay: assert property (p_short_delay)
    else $error("short fault flagged before delay");

  property p_fault_keep;
    r.flags[FL_LED] && start && !rd_fl && en_pin |=> r.flags[FL_LED];
  endproperty
  a_fault_keep: assert property (p_fault_keep)
    else $error("new pulse cleared LED fault");

  property p_pa1_event;
    set_v[FL_PA1] && en_pin |=> r.flags[FL_PA1];
  endproperty
  a_pa1_event: assert property (p_pa1_event)
    else $error("first pin event lost");

  property p_mode_cleared;
    $fell(r.flash) |-> r.en[1:0] == LED_OFF;
  endproperty
  a_mode_cleared: assert property (p_mode_cleared)
    else $error("mode field not cleared at pulse end");

  property p_vin_lock;
    r.vin_lock && vlow |=> r.vin_lock;
  endproperty
  a_vin_lock: assert property (p_vin_lock)
    else $error("supply cutback lifted while low");

  c_timeout: cover property (r.flash ##1 r.flags[FL_TIMEOUT]);
  c_read:    cover property (rd_fl && r.flags != 8'h00);
  c_thermal: cover property (r.therm_lock ##1 !r.therm_lock);
  c_write:   cover property (wr_en);

endmodule : ffi_fault_flags

// [tb/ffi_host_model.sv]
// Purpose: Behavioural two-wire bus controller for the target port.
// Assumes: Link clock of 64 ns paces every bus phase.
// Notes:   SCL idles high and stands still between frames.
`timescale 1ns/100ps
module ffi_host_model (
  // Link clock
  input  wire logic i_link_clk,
  // Bus wires
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  task automatic half();
    repeat (2) @(posedge i_link_clk);
    #1;
  endtask : half

  // Data moves only while SCL is low
  task automatic bit_xfer(input logic b, output logic r);
    o_sda_low = ~b;
    half();
    o_scl = 1'b1;
    half();
    r = i_sda;
    o_scl = 1'b0;
    @(posedge i_link_clk);
    #1;
  endtask : bit_xfer

  // Start and repeated start alike
  task automatic start();
    o_sda_low = 1'b0;
    half();
    o_scl = 1'b1;
    half();
    o_sda_low = 1'b1;
    half();
    o_scl = 1'b0;
    half();
  endtask : start

  task automatic stop();
    o_sda_low = 1'b1;
    half();
    o_scl = 1'b1;
    half();
    o_sda_low = 1'b0;
    half();
  endtask : stop

  // Released on the 9th clock for the target to answer
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], r);
    end
    bit_xfer(1'b1, r);
    ack = ~r;
  endtask : wr_byte

  task automatic rd_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, r);
      d[i] = r;
    end
    bit_xfer(nack, r);
  endtask : rd_byte
endmodule : ffi_host_model

// [tb/tb.sv]
// Purpose: Self-checking bench of the fault flag bank.
// Assumes: Host model paces the bus from its own link clock.
// Notes:   Timeout step and short delay are shortened.
`timescale 1ns/100ps
module tb;
  import ffi_pkg::*;
  localparam int LIMIT = 95000;
  logic       clk = 0, lclk = 0, rst = 1;
  logic       en_pin = 0, strobe = 0, pa1 = 0, pa2 = 0;
  logic       otemp = 0, output_overvoltage_comparator = 0, shrt = 0, therm = 0, supply = 0;
  logic       scl, sda_low, sda_oe, sda_val, boost;
  logic [1:0] mode;
  wire        sda = ~(sda_low | sda_oe);
  int         fail_count = 0, samples_checked = 0, cycles = 0;

  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    #7;
    forever #32 lclk = ~lclk;
  end

  ffi_host_model host (.i_link_clk(lclk), .i_sda(sda), .o_scl(scl),
    .o_sda_low(sda_low));
  ffi_fault_flags #(.P_TO_STEP_CYC(20), .P_SHORT_CYC(30)) DUT (
    .i_clk(clk), .i_rst(rst), .i_scl(scl), .i_sda(sda),
    .o_sda(sda_val), .o_sda_oe(sda_oe), .i_hardware_enable_pin(en_pin),
    .i_strobe(strobe), .i_first_interrupt_pin(pa1),
    .i_second_interrupt_pin(pa2), .i_over_temp(otemp),
    .i_output_overvoltage_comparator(output_overvoltage_comparator), .i_led_short(shrt),
    .i_thermistor_low(therm), .i_supply_low(supply),
    .o_boost_en(boost), .o_led_mode(mode));

  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
    logic a0, a1, a2;
    host.start();
    host.wr_byte(8'hA6, a0);
    host.wr_byte(idx, a1);
    host.wr_byte(d, a2);
    host.stop();
    cyc(1);
    chk("write ack", 8'h07, {5'h00, a0, a1, a2});
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] idx, input logic [7:0] e);
    logic a0, a1, a2;
    logic [7:0] d;
    host.start();
    host.wr_byte(8'hA6, a0);
    host.wr_byte(idx, a1);
    host.start();
    host.wr_byte(8'hA7, a2);
    host.rd_byte(1'b1, d);
    host.stop();
    cyc(1);
    chk("read ack", 8'h07, {5'h00, a0, a1, a2});
    chk("register", e, d);
  endtask : reg_rd

  task automatic wait_mode(input logic [1:0] e, input int lim);
    int n;
    n = 0;
    while (mode !== e && n < lim) begin
      cyc(1);
      n++;
    end
    chk("led mode", {6'h00, e}, {6'h00, mode});
  endtask : wait_mode

  task automatic t_reset();
    logic [7:0] ix [11];
    logic [7:0] rv [11];
    ix = '{IDX_ENABLE, IDX_IND, IDX_GPIO, IDX_VIN, IDX_TORCH, IDX_FLASH,
           IDX_DUR, IDX_FLAGS, IDX_CFG1, IDX_CFG2, 8'h30};
    rv = '{RST_ENABLE, RST_IND, RST_GPIO, RST_VIN, RST_TORCH, RST_FLASH,
           RST_DUR, RST_FLAGS, RST_CFG1, RST_CFG2, 8'h00};
    chk("boost", 8'h00, {7'h00, boost});
    chk("sda value", 8'h00, {7'h00, sda_val});
    for (int i = 0; i < 11; i++) begin
      reg_rd(ix[i], rv[i]);
    end
  endtask : t_reset

  task automatic t_address();
    logic a0, a1, a2;
    host.start();
    host.wr_byte(8'hA4, a0);
    host.wr_byte(IDX_TORCH, a1);
    host.wr_byte(8'h55, a2);
    host.stop();
    chk("foreign ack", 8'h00, {5'h00, a0, a1, a2});
    reg_rd(IDX_TORCH, RST_TORCH);
    reg_wr(IDX_TORCH, 8'h3C);
    reg_rd(IDX_TORCH, 8'h3C);
  endtask : t_address

  // Shortest timeout: one step of the shortened count
  task automatic fire_timeout();
    reg_wr(IDX_DUR, 8'hE0);
    reg_wr(IDX_ENABLE, 8'hFB);
    wait_mode(LED_OFF, 100);
  endtask : fire_timeout

  task automatic t_timeout();
    fire_timeout();
    reg_rd(IDX_ENABLE, 8'hF8);
    reg_rd(IDX_FLAGS, 8'h01);
    reg_rd(IDX_FLAGS, 8'h00);
    fire_timeout();
    reg_wr(IDX_DUR, 8'hEF);
    strobe = 1'b1;
    wait_mode(LED_FLASH, 20);
    cyc(40);
    strobe = 1'b0;
    wait_mode(LED_OFF, 10);
    reg_rd(IDX_FLAGS, 8'h00);
    fire_timeout();
    en_pin = 1'b0;
    cyc(10);
    en_pin = 1'b1;
    cyc(10);
    reg_rd(IDX_FLAGS, 8'h00);
  endtask : t_timeout

  task automatic t_overtemp();
    reg_wr(IDX_ENABLE, 8'hFA);
    wait_mode(LED_TORCH, 10);
    chk("boost on", 8'h01, {7'h00, boost});
    otemp = 1'b1;
    wait_mode(LED_OFF, 10);
    chk("boost", 8'h00, {7'h00, boost});
    otemp = 1'b0;
    reg_wr(IDX_ENABLE, 8'hFA);
    cyc(10);
    chk("locked mode", 8'h00, {6'h00, mode});
    reg_rd(IDX_FLAGS, 8'h02);
    reg_wr(IDX_ENABLE, 8'hFA);
    wait_mode(LED_TORCH, 10);
  endtask : t_overtemp

  task automatic t_led_fault();
    output_overvoltage_comparator = 1'b1;
    cyc(100);
    output_overvoltage_comparator = 1'b0;
    reg_rd(IDX_FLAGS, 8'h00);
    output_overvoltage_comparator = 1'b1;
    cyc(210);
    output_overvoltage_comparator = 1'b0;
    reg_rd(IDX_FLAGS, 8'h04);
    reg_wr(IDX_ENABLE, 8'hFA);
    shrt = 1'b1;
    cyc(20);
    shrt = 1'b0;
    reg_rd(IDX_FLAGS, 8'h00);
    shrt = 1'b1;
    cyc(40);
    shrt = 1'b0;
    reg_wr(IDX_ENABLE, 8'hFB);
    reg_rd(IDX_FLAGS, 8'h05);
  endtask : t_led_fault

  task automatic t_events();
    pa1 = 1'b1;
    cyc(10);
    pa1 = 1'b0;
    reg_rd(IDX_FLAGS, 8'h08);
    reg_wr(IDX_CFG1, 8'h2A);
    pa2 = 1'b1;
    cyc(10);
    reg_rd(IDX_FLAGS, 8'h00);
    pa2 = 1'b0;
    cyc(10);
    reg_rd(IDX_FLAGS, 8'h10);
  endtask : t_events

  task automatic t_monitors();
    reg_wr(IDX_VIN, 8'hF9);
    supply = 1'b1;
    cyc(10);
    supply = 1'b0;
    reg_rd(IDX_FLAGS, 8'h80);
    reg_wr(IDX_CFG1, 8'h3A);
    reg_wr(IDX_CFG2, 8'hF2);
    reg_wr(IDX_ENABLE, 8'hFA);
    therm = 1'b1;
    wait_mode(LED_OFF, 20);
    therm = 1'b0;
    cyc(20);
    chk("cut mode", 8'h00, {6'h00, mode});
    reg_rd(IDX_FLAGS, 8'h20);
    wait_mode(LED_TORCH, 20);
  endtask : t_monitors

  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    en_pin = 1'b1;
    cyc(10);
    t_reset();
    t_address();
    t_timeout();
    t_overtemp();
    t_led_fault();
    t_events();
    t_monitors();
    tally_and_finish();
  end
endmodule : tb
